// ===== cobid_asserts.sv
// cobid_asserts: port-level timing checks of the classifier.
// assumes it is bound onto cobid_classifier; one clock, async reset.
`timescale 1ns/1ps
module cobid_asserts #(
    parameter int HB_PERIOD_MS = 100,
    parameter int CLK_KHZ = 40000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] nodeAddr,
    input wire logic cfgWrite,
    input wire logic cfgRestore,
    input wire logic heartbeatEn,
    input wire logic rxValid,
    input wire logic rxExtended,
    input wire logic [10:0] rxId,
    input wire logic [7:0] rxByte0,
    input wire logic classValid,
    input wire logic [3:0] classKind,
    input wire logic [3:0] funcCode,
    input wire logic [6:0] srcAddr,
    input wire logic unclaimed,
    input wire logic nmtCmdValid,
    input wire logic [7:0] nmtCmd,
    input wire logic heartbeatReq,
    input wire logic [10:0] emcyId
);
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [31:0] hbCnt_q;
    // one cycle of slack covers either reading of the first pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst || !heartbeatEn || heartbeatReq) begin
            hbCnt_q <= 32'h0;
        end else begin
            hbCnt_q <= hbCnt_q + 32'h1;
        end
    end
    AST_ONE_ANSWER: assert property (
        rxValid |=> classValid ^ unclaimed)
        else $error("frame answer missing or doubled");
    AST_NO_ANSWER: assert property (
        !rxValid |=> !classValid && !unclaimed)
        else $error("answer without frame");
    AST_EXT: assert property (
        rxValid && rxExtended |=> unclaimed)
        else $error("extended frame classified");
    AST_SPLIT: assert property (
        rxValid |=> {funcCode, srcAddr} == $past(rxId))
        else $error("identifier split wrong");
    AST_NMT: assert property (
        rxValid && !rxExtended && rxId == 11'h000 |=> classKind == 4'h1)
        else $error("management frame kind wrong");
    AST_SYNC: assert property (
        rxValid && !rxExtended && rxId == 11'h080 |=> classKind == 4'h2)
        else $error("sync frame kind wrong");
    AST_CMD: assert property (
        nmtCmdValid |-> classValid && nmtCmd == $past(rxByte0))
        else $error("command not from first byte");
    AST_EMCY: assert property (
        cfgRestore ##1 !cfgWrite
        |-> ##1 emcyId == {4'h1, $past(nodeAddr, 2)})
        else $error("emergency default wrong");
    AST_HB_SRC: assert property (
        heartbeatReq |-> $past(heartbeatEn))
        else $error("heartbeat while disabled");
    AST_HB_GAP: assert property (
        heartbeatEn |-> hbCnt_q <= HB_PERIOD_MS * CLK_KHZ + 1)
        else $error("heartbeat period overrun");
    cover property (nmtCmdValid);
    cover property (rxValid && rxExtended ##1 unclaimed);
    cover property (heartbeatReq);
endmodule
bind cobid_classifier cobid_asserts #(
    .HB_PERIOD_MS(HB_PERIOD_MS),
    .CLK_KHZ(CLK_KHZ)
) cobid_asserts_inst (.*);

// ===== cobid_can_model.sv
// cobid_can_model: frame controller handing received frames over.
// assumes the caller enters its tasks at a falling edge of ref_clk.
`timescale 1ns/1ps
module cobid_can_model (
    input wire logic ref_clk,
    output logic rxValid,
    output logic rxExtended,
    output logic [10:0] rxId,
    output logic [7:0] rxByte0,
    output logic [7:0] rxByte1
);
    // ****************************************
    // frame delivery
    // ****************************************
    initial rxValid = 1'b0;
    task automatic send(input logic [10:0] id, input logic ext,
            input logic [7:0] b0, input logic [7:0] b1);
        rxValid = 1'b1;
        rxExtended = ext;
        rxId = id;
        rxByte0 = b0;
        rxByte1 = b1;
        @(negedge ref_clk);
    endtask
    // stale fields are inverted so a late sample cannot look right
    task automatic idle();
        rxValid = 1'b0;
        {rxExtended, rxId, rxByte0, rxByte1} =
            ~{rxExtended, rxId, rxByte0, rxByte1};
        @(negedge ref_clk);
    endtask
endmodule

// ===== cobid_classifier.sv
// cobid_classifier: builds default object identifiers from the node address,
// holds a configurable identifier table, classifies received frames and
// decodes network management state commands addressed to this node.
// assumes a frame controller on ref_clk giving one-cycle receive strobes.
`timescale 1ns/1ps
module cobid_classifier #(
    parameter int HB_PERIOD_MS = 100,
    parameter int CLK_KHZ = 40000
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [6:0] nodeAddr,
    input wire logic cfgWrite,
    input wire logic [3:0] cfgSlot,
    input wire logic [10:0] cfgId,
    input wire logic cfgRestore,
    input wire logic heartbeatEn,
    input wire logic rxValid,
    input wire logic rxExtended,
    input wire logic [10:0] rxId,
    input wire logic [7:0] rxByte0,
    input wire logic [7:0] rxByte1,
    output logic classValid,
    output logic [3:0] classKind,
    output logic [1:0] pdoIndex,
    output logic [3:0] funcCode,
    output logic [6:0] srcAddr,
    output logic unclaimed,
    output logic nmtCmdValid,
    output logic [7:0] nmtCmd,
    output logic heartbeatReq,
    output logic [10:0] heartbeatId,
    output logic [10:0] emcyId,
    output logic [10:0] tpdoId1,
    output logic [10:0] sdoTxId
);
    // ******************************************************************
    // configured identifier table
    // ******************************************************************
    logic [10:0] idTab_q [cobid_pkg::OBJ_N];
    logic [6:0] nodeAddr_q;

    function automatic logic [10:0] defId(input int slot,
                                          input logic [6:0] a);
        logic [3:0] fc;
        fc = cobid_pkg::FC_NMT;
        case (slot)
            cobid_pkg::S_EMCY: fc = cobid_pkg::FC_EMCY;
            cobid_pkg::S_TPDO1: fc = cobid_pkg::FC_TPDO1;
            cobid_pkg::S_RPDO1: fc = cobid_pkg::FC_RPDO1;
            cobid_pkg::S_TPDO2: fc = cobid_pkg::FC_TPDO2;
            cobid_pkg::S_RPDO2: fc = cobid_pkg::FC_RPDO2;
            cobid_pkg::S_TPDO3: fc = cobid_pkg::FC_TPDO3;
            cobid_pkg::S_RPDO3: fc = cobid_pkg::FC_RPDO3;
            cobid_pkg::S_TPDO4: fc = cobid_pkg::FC_TPDO4;
            cobid_pkg::S_RPDO4: fc = cobid_pkg::FC_RPDO4;
            cobid_pkg::S_SDOTX: fc = cobid_pkg::FC_SDOTX;
            cobid_pkg::S_SDORX: fc = cobid_pkg::FC_SDORX;
            cobid_pkg::S_GUARD: fc = cobid_pkg::FC_GUARD;
            default: fc = cobid_pkg::FC_NMT;
        endcase
        if (slot == cobid_pkg::S_SYNC) begin
            defId = cobid_pkg::ID_SYNC;
        end else begin
            defId = {fc, a};
        end
    endfunction

    // address and table loaded together after restore so the table never
    // mixes defaults of two different node addresses
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nodeAddr_q <= cobid_pkg::NODE_RST;
            for (int i = 0; i < cobid_pkg::OBJ_N; i++) begin
                idTab_q[i] <= defId(i, cobid_pkg::NODE_RST);
            end
        end else if (cfgRestore) begin
            nodeAddr_q <= nodeAddr;
            for (int i = 0; i < cobid_pkg::OBJ_N; i++) begin
                idTab_q[i] <= defId(i, nodeAddr);
            end
        end else if (cfgWrite && cfgSlot < 4'(cobid_pkg::OBJ_N)) begin
            idTab_q[cfgSlot] <= cfgId;
        end
    end

    // ******************************************************************
    // receive classification
    // ******************************************************************
    // an extended frame never counts as an object, whatever its id bits
    logic stdFrame;
    logic isMgmt;
    logic [cobid_pkg::OBJ_N-1:0] slotHit;
    logic hit;
    logic [3:0] kind;
    logic [1:0] pIdx;

    assign stdFrame = rxValid && !rxExtended;
    assign isMgmt = rxId == cobid_pkg::ID_NMT;

    // one comparator per slot; all compare in parallel so the answer is
    // ready one cycle after the strobe whichever slot matches
    for (genvar g = 0; g < cobid_pkg::OBJ_N; g++) begin : gSlot
        assign slotHit[g] = rxId == idTab_q[g];
    end

    // lowest matching slot wins; process slots precede every service slot except emergency,
    // so a duplicate configured id resolves toward the process object unless it matches the emergency slot
    always_comb begin
        hit = 1'b0;
        kind = cobid_pkg::COBID_K_NONE;
        pIdx = 2'h0;
        if (isMgmt) begin
            hit = 1'b1;
            kind = cobid_pkg::COBID_K_NMT;
        end else begin
            for (int i = 0; i < cobid_pkg::OBJ_N; i++) begin
                if (!hit && slotHit[i]) begin
                    hit = 1'b1;
                    case (i)
                        cobid_pkg::S_EMCY: kind = cobid_pkg::COBID_K_EMCY;
                        cobid_pkg::S_TPDO1: begin
                            kind = cobid_pkg::COBID_K_TPDO;
                            pIdx = 2'h0;
                        end
                        cobid_pkg::S_RPDO1: begin
                            kind = cobid_pkg::COBID_K_RPDO;
                            pIdx = 2'h0;
                        end
                        cobid_pkg::S_TPDO2: begin
                            kind = cobid_pkg::COBID_K_TPDO;
                            pIdx = 2'h1;
                        end
                        cobid_pkg::S_RPDO2: begin
                            kind = cobid_pkg::COBID_K_RPDO;
                            pIdx = 2'h1;
                        end
                        cobid_pkg::S_TPDO3: begin
                            kind = cobid_pkg::COBID_K_TPDO;
                            pIdx = 2'h2;
                        end
                        cobid_pkg::S_RPDO3: begin
                            kind = cobid_pkg::COBID_K_RPDO;
                            pIdx = 2'h2;
                        end
                        cobid_pkg::S_TPDO4: begin
                            kind = cobid_pkg::COBID_K_TPDO;
                            pIdx = 2'h3;
                        end
                        cobid_pkg::S_RPDO4: begin
                            kind = cobid_pkg::COBID_K_RPDO;
                            pIdx = 2'h3;
                        end
                        cobid_pkg::S_SDOTX: kind = cobid_pkg::COBID_K_SDOTX;
                        cobid_pkg::S_SDORX: kind = cobid_pkg::COBID_K_SDORX;
                        cobid_pkg::S_GUARD: kind = cobid_pkg::COBID_K_GUARD;
                        cobid_pkg::S_SYNC: kind = cobid_pkg::COBID_K_SYNC;
                        default: kind = cobid_pkg::COBID_K_NONE;
                    endcase
                end
            end
        end
    end

    // exactly one of the two strobes answers each received frame
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            classValid <= 1'b0;
            unclaimed <= 1'b0;
        end else begin
            classValid <= stdFrame && hit;
            unclaimed <= rxValid && (rxExtended || !hit);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            classKind <= cobid_pkg::COBID_K_NONE;
            pdoIndex <= 2'h0;
        end else begin
            classKind <= (stdFrame && hit) ? kind : cobid_pkg::COBID_K_NONE;
            pdoIndex <= pIdx;
        end
    end

    // ******************************************************************
    // identifier split
    // ******************************************************************
    // follows the id every cycle; only meaningful beside a strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            funcCode <= 4'h0;
            srcAddr <= 7'h00;
        end else begin
            funcCode <= rxId[10:7];
            srcAddr <= rxId[6:0];
        end
    end

    // ******************************************************************
    // management commands
    // ******************************************************************
    // byte 0 is the command, byte 1 the target node; 0 addresses all nodes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nmtCmdValid <= 1'b0;
            nmtCmd <= 8'h00;
        end else begin
            nmtCmdValid <= stdFrame && isMgmt
                           && (rxByte1 == 8'h00
                               || rxByte1 == {1'b0, nodeAddr_q});
            nmtCmd <= rxByte0;
        end
    end

    // ******************************************************************
    // heartbeat timer and transmit identifiers
    // ******************************************************************
    localparam int HB_CYC = HB_PERIOD_MS * CLK_KHZ;
    logic [31:0] hbCnt_q;
    logic hbWrap;

    // counter restarts when disabled, so the first alive message comes a
    // full period after enable, never after a stale partial count
    assign hbWrap = hbCnt_q >= 32'(HB_CYC - 1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hbCnt_q <= 32'h0;
        end else if (!heartbeatEn || hbWrap) begin
            hbCnt_q <= 32'h0;
        end else begin
            hbCnt_q <= hbCnt_q + 32'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            heartbeatReq <= 1'b0;
        end else begin
            heartbeatReq <= heartbeatEn && hbWrap;
        end
    end

    // transmit ids track the table; numeric order gives bus priority
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            heartbeatId <= 11'h000;
            emcyId <= 11'h000;
        end else begin
            heartbeatId <= idTab_q[cobid_pkg::S_GUARD];
            emcyId <= idTab_q[cobid_pkg::S_EMCY];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tpdoId1 <= 11'h000;
            sdoTxId <= 11'h000;
        end else begin
            tpdoId1 <= idTab_q[cobid_pkg::S_TPDO1];
            sdoTxId <= idTab_q[cobid_pkg::S_SDOTX];
        end
    end
endmodule

// ===== cobid_classifier_tb.sv
// cobid_classifier_tb: frames, configuration and heartbeat at the ports.
// assumes cobid_can_model and the bound checker are compiled first.
`timescale 1ns/1ps
module cobid_classifier_tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [6:0] nodeAddr = 7'h01;
    logic cfgWrite = 1'b0;
    logic [3:0] cfgSlot = 4'h0;
    logic [10:0] cfgId = 11'h000;
    logic cfgRestore = 1'b0;
    logic heartbeatEn = 1'b0;
    logic rxValid, rxExtended, classValid, unclaimed;
    logic nmtCmdValid, heartbeatReq;
    logic [10:0] rxId, heartbeatId, emcyId, tpdoId1, sdoTxId;
    logic [7:0] rxByte0, rxByte1, nmtCmd, c;
    logic [3:0] classKind, funcCode;
    logic [1:0] pdoIndex;
    logic [6:0] srcAddr, n;
    logic [14:0] expQ[$];
    logic [14:0] e;
    logic [10:0] idQ[$];
    logic [10:0] ei;
    int miscompares = 0;
    int checks = 0;
    int hb;
    // ****************************************
    // harness
    // ****************************************
    always #12.5 ref_clk = ~ref_clk;
    cobid_classifier #(.HB_PERIOD_MS(8), .CLK_KHZ(1)) cobid_classifier_inst (.*);
    cobid_can_model cobid_can_model_inst (.*);
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // k holds unclaimed, kind and pdo number; c the command byte
    task automatic frame(input logic [10:0] id, input logic ext,
            input logic [6:0] k);
        expQ.push_back({k, c});
        idQ.push_back(id);
        cobid_can_model_inst.send(id, ext, c, n);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(negedge ref_clk) begin
        if (!rst && (classValid === 1'b1 || unclaimed === 1'b1)) begin
            e = (expQ.size() > 0) ? expQ.pop_front() : 15'h7fff;
            ei = (idQ.size() > 0) ? idQ.pop_front() : 11'h7ff;
            chk({funcCode, srcAddr} === ei, "id split");
            chk({classValid, unclaimed} === {~e[14], e[14]}, "claim");
            chk(e[14] || classKind === e[13:10], "kind");
            chk(e[13:11] != 3'h2 || pdoIndex === e[9:8], "pdo");
            chk(nmtCmdValid === (e[14:10] == 5'h01), "cmd valid");
            chk(e[13:10] != 4'h1 || nmtCmd === e[7:0], "cmd byte");
        end
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        void'($urandom(78));
        c = 8'h00;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        n = 7'($urandom_range(127, 1));
        nodeAddr = n;
        cfgRestore = 1'b1;
        @(negedge ref_clk);
        cfgRestore = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(emcyId === {4'h1, n}, "emcy id");
        chk(tpdoId1 === {4'h3, n}, "tpdo id");
        chk(sdoTxId === {4'hb, n}, "sdo id");
        chk(heartbeatId === {4'he, n}, "guard id");
        chk((tpdoId1 < sdoTxId) === 1'b1, "order");
        for (int f = 3; f <= 10; f++) begin
            frame({4'(f), n}, 1'b0,
                  {1'b0, f[0] ? 4'h5 : 4'h4, 2'((f - 3) / 2)});
        end
        frame({4'h1, n}, 1'b0, {5'h03, 2'h0});
        frame({4'hc, n}, 1'b0, {5'h06, 2'h0});
        frame({4'hb, n}, 1'b0, {5'h07, 2'h0});
        frame({4'he, n}, 1'b0, {5'h08, 2'h0});
        frame(11'h080, 1'b0, {5'h02, 2'h0});
        c = 8'($urandom());
        frame(11'h000, 1'b0, {5'h01, 2'h0});
        frame({4'h2, n}, 1'b0, {5'h10, 2'h0});
        frame({4'h3, n ^ 7'h40}, 1'b0, {5'h10, 2'h0});
        frame({4'h3, n}, 1'b1, {5'h10, 2'h0});
        cobid_can_model_inst.idle();
        {cfgWrite, cfgSlot, cfgId} = {1'b1, 4'hb, 11'h123};
        @(negedge ref_clk);
        cfgWrite = 1'b0;
        frame(11'h123, 1'b0, {5'h08, 2'h0});
        frame({4'he, n}, 1'b0, {5'h10, 2'h0});
        cobid_can_model_inst.idle();
        chk(heartbeatId === 11'h123, "configured id");
        heartbeatEn = 1'b1;
        hb = 0;
        repeat (36) @(negedge ref_clk) hb += (heartbeatReq === 1'b1);
        chk(hb == 4, "heartbeat count");
        heartbeatEn = 1'b0;
        hb = 0;
        repeat (20) @(negedge ref_clk) hb += (heartbeatReq === 1'b1);
        chk(hb == 0, "heartbeat off");
        for (int i = 0; i < 10 && expQ.size() != 0; i++) @(negedge ref_clk);
        chk(expQ.size() == 0, "results missing");
        complete_run();
    end
endmodule

// ===== cobid_pkg.sv
// cobid_pkg: constants for the object identifier builder and classifier.
// assumes nothing of its surroundings; used by cobid_classifier only.
package cobid_pkg;
    localparam int ID_W = 11;
    localparam int FC_W = 4;
    localparam int NODE_W = 7;
    localparam logic [3:0] FC_NMT = 4'h0;
    localparam logic [3:0] FC_EMCY = 4'h1;
    localparam logic [3:0] FC_TPDO1 = 4'h3;
    localparam logic [3:0] FC_RPDO1 = 4'h4;
    localparam logic [3:0] FC_TPDO2 = 4'h5;
    localparam logic [3:0] FC_RPDO2 = 4'h6;
    localparam logic [3:0] FC_TPDO3 = 4'h7;
    localparam logic [3:0] FC_RPDO3 = 4'h8;
    localparam logic [3:0] FC_TPDO4 = 4'h9;
    localparam logic [3:0] FC_RPDO4 = 4'ha;
    localparam logic [3:0] FC_SDOTX = 4'hb;
    localparam logic [3:0] FC_SDORX = 4'hc;
    localparam logic [3:0] FC_GUARD = 4'he;
    localparam logic [10:0] ID_NMT = 11'h000;
    localparam logic [10:0] ID_SYNC = 11'h080;
    localparam logic [6:0] NODE_RST = 7'h01;
    localparam int CFG_NONE = 0;
    // object kinds reported on the classify output
    typedef enum logic [3:0] {
        COBID_K_NONE = 4'h0, COBID_K_NMT = 4'h1, COBID_K_SYNC = 4'h2,
        COBID_K_EMCY = 4'h3, COBID_K_RPDO = 4'h4, COBID_K_TPDO = 4'h5,
        COBID_K_SDORX = 4'h6, COBID_K_SDOTX = 4'h7, COBID_K_GUARD = 4'h8
    } cobid_kind_t;
    localparam int OBJ_N = 13;
    // configured identifier table slot indices
    localparam int S_EMCY = 0;
    localparam int S_TPDO1 = 1;
    localparam int S_RPDO1 = 2;
    localparam int S_TPDO2 = 3;
    localparam int S_RPDO2 = 4;
    localparam int S_TPDO3 = 5;
    localparam int S_RPDO3 = 6;
    localparam int S_TPDO4 = 7;
    localparam int S_RPDO4 = 8;
    localparam int S_SDOTX = 9;
    localparam int S_SDORX = 10;
    localparam int S_GUARD = 11;
    localparam int S_SYNC = 12;
    localparam logic [3:0] NMT_START = 4'h1;
endpackage
